// File: logic/pc_stack_indirect.sv
// Program counter, return stack and indirect data pointer logic
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
// Function
// RULE_01: PC increments by one each cycle unless loaded by instruction.
// RULE_02: Jump loads PC bits 8:0 from the instruction field.
// RULE_03: Branches take PC bit 9 from status bit 5.
// RULE_04: PC bits 7:0 readable and writable as data register.
// RULE_05: Call or low-byte write loads bits 7:0, clears PC bit 8.
// RULE_06: Reset sets PC to last location; next increment wraps to zero.
// RULE_07: Reset clears status page select, choosing page 0.
// RULE_08: Two-entry 12-bit stack used only by call and literal return.
// RULE_09: Call copies level 1 to 2, then pushes PC plus one.
// RULE_10: Return loads PC from level 1, copies level 2 to 1.
// RULE_11: Literal return loads accumulator with instruction literal.
// RULE_12: Indirect alias has no storage; accesses redirect via pointer.
// RULE_13: Reading the alias through itself returns 00h.
// RULE_14: Writing the alias through itself changes no register.
// RULE_15: Pointer bits 4:0 select data addresses 00h to 1Fh.
// RULE_16: Unbanked variant: pointer bits 6:5 read as ones.
// RULE_17: Banked variant: pointer bit 5 selects bank, bit 6 reads one.
// RULE_18: PC is 10 bits; bit 9 zero unless two pages.
module pc_stack_indirect (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cycle_en,
  input wire pc_stack_pkg::pc_op_e pc_op,
  input wire logic [pc_stack_pkg::INSN_W-1:0] insn_word,
  input wire logic [pc_stack_pkg::DATA_W-1:0] pcl_wr_data,
  input wire logic [pc_stack_pkg::DATA_W-1:0] status_reg,
  input wire logic ptr_wr,
  input wire logic [pc_stack_pkg::DATA_W-1:0] ptr_wr_data,
  input wire logic [pc_stack_pkg::FADDR_W-1:0] file_addr,
  input wire logic file_wr,
  input wire logic [pc_stack_pkg::DATA_W-1:0] file_wr_data,
  input wire logic [pc_stack_pkg::DATA_W-1:0] ram_rd_data,
  output logic [pc_stack_pkg::PC_W-1:0] pc,
  output logic [pc_stack_pkg::DATA_W-1:0] ptr_read,
  output logic [pc_stack_pkg::DATA_W-1:0] acc,
  output logic acc_load,
  output logic status_page_clr,
  output logic [5:0] ram_addr,
  output logic ram_wr,
  output logic [pc_stack_pkg::DATA_W-1:0] ram_wr_data,
  output logic [pc_stack_pkg::DATA_W-1:0] ind_rd_data
);
  import pc_stack_pkg::*;

  logic [1:0] ctrl_ff, nxt_ctrl;
  logic [PC_W-1:0] pc_ff, nxt_pc;
  logic [STK_W-1:0] stk1_ff, nxt_stk1;
  logic [STK_W-1:0] stk2_ff, nxt_stk2;
  logic [DATA_W-1:0] acc_ff, nxt_acc;
  logic acc_load_ff, nxt_acc_load;
  logic [DATA_W-1:0] ptr_ff, nxt_ptr;
  logic page_clr_ff, nxt_page_clr;
  logic banked;
  logic two_page;
  logic bus_wr;
  logic bus_rd_valid;
  logic ctrl_bus_wr;
  logic ptr_bus_wr;
  logic ptr_core_wr;
  logic ind_sel;
  logic ind_self;
  logic [DATA_W-1:0] pcl_val;
  logic [DATA_W-1:0] ptr_val;

  // Apply page bit only on two-page variant
  function automatic logic [PC_W-1:0] with_page(
    input logic [PC_W-1:0] v,
    input logic page,
    input logic en
  );
    logic [PC_W-1:0] r;
    r = v;
    r[PC_PAGE_BIT] = page & en;
    return r;
  endfunction

  // Pointer read value with bit 6, and bit 5 when unbanked, forced high and bit 7 forced low
  function automatic logic [DATA_W-1:0] ptr_view(
    input logic [DATA_W-1:0] p,
    input logic bank_en
  );
    logic [DATA_W-1:0] r;
    r = p;
    r[PTR_SPARE_BIT] = 1'b0;
    r[PTR_FIXED_BIT] = 1'b1;
    if (!bank_en) begin
      r[PTR_BANK_BIT] = 1'b1;
    end
    return r;
  endfunction

  // Next sequential program address
  function automatic logic [PC_W-1:0] pc_inc(
    input logic [PC_W-1:0] v
  );
    return v + PC_ONE;
  endfunction

  // Index field of the indirect pointer
  function automatic logic [FADDR_W-1:0] ptr_index(
    input logic [DATA_W-1:0] p
  );
    return p[FADDR_W-1:0];
  endfunction

  // Data memory address reached through the indirect alias
  function automatic logic [FADDR_W:0] ind_addr(
    input logic [DATA_W-1:0] p,
    input logic bank_en
  );
    return {bank_en & p[PTR_BANK_BIT], ptr_index(p)};
  endfunction

  assign banked = ctrl_ff[CTRL_BANKED_BIT];
  assign two_page = ctrl_ff[CTRL_TWO_PAGE_BIT];
  assign bus_wr = psel & penable & pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // Indirect alias decoding
  assign ind_sel = (file_addr == IND_ALIAS_ADDR); // [RULE_12]
  assign ind_self = (ptr_index(ptr_ff) == IND_ALIAS_ADDR); // [RULE_13]
  assign pcl_val = pc_ff[7:0]; // [RULE_04]
  assign ptr_val = ptr_view(ptr_ff, banked); // [RULE_16] [RULE_17]
  assign ptr_read = ptr_val;

  // Register writes from the bus and from the core
  assign ctrl_bus_wr = bus_wr & (paddr == OFF_CTRL);
  assign ptr_bus_wr = bus_wr & (paddr == OFF_PTR);
  assign ptr_core_wr = cycle_en & ptr_wr;

  always_comb begin
    ram_addr = {1'b0, file_addr};
    ram_wr = file_wr;
    ram_wr_data = file_wr_data;
    ind_rd_data = ram_rd_data;
    if (ind_sel) begin
      ram_addr = ind_addr(ptr_ff, banked); // [RULE_15] [RULE_17]
      ram_wr = file_wr & ~ind_self; // [RULE_14]
      if (ind_self) begin
        ind_rd_data = IND_SELF_READ; // [RULE_13]
      end
    end
  end

  // Program counter, return stack and accumulator next state
  always_comb begin
    nxt_pc = pc_ff;
    nxt_stk1 = stk1_ff;
    nxt_stk2 = stk2_ff;
    nxt_acc = acc_ff;
    nxt_acc_load = 1'b0;
    if (cycle_en) begin
      nxt_pc = pc_inc(pc_ff); // [RULE_01]
      if (!two_page) begin
        nxt_pc[PC_PAGE_BIT] = 1'b0; // [RULE_18]
      end
      case (pc_op)
        OP_JUMP: begin
          nxt_pc = with_page({1'b0, insn_word[PC_MID_BIT:0]},
            status_reg[STATUS_PAGE_BIT], two_page); // [RULE_02] [RULE_03]
        end
        OP_CALL: begin
          nxt_stk2 = stk1_ff; // [RULE_09]
          nxt_stk1 = STK_W'(pc_inc(pc_ff)); // [RULE_09] [RULE_08]
          nxt_pc = with_page({2'b00, insn_word[DATA_W-1:0]},
            status_reg[STATUS_PAGE_BIT], two_page); // [RULE_05] [RULE_03]
        end
        OP_RETURN_WITH_LITERAL: begin
          nxt_pc = stk1_ff[PC_W-1:0]; // [RULE_10]
          nxt_stk1 = stk2_ff; // [RULE_10]
          nxt_acc = insn_word[DATA_W-1:0]; // [RULE_11]
          nxt_acc_load = 1'b1; // [RULE_11]
        end
        OP_PCL_WR: begin
          nxt_pc = with_page({2'b00, pcl_wr_data},
            status_reg[STATUS_PAGE_BIT], two_page); // [RULE_05] [RULE_04]
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_ff <= PC_LAST_HI; // [RULE_06]
      stk1_ff <= '0;
      stk2_ff <= '0;
      acc_ff <= '0;
      acc_load_ff <= 1'b0;
    end else begin
      pc_ff <= nxt_pc;
      stk1_ff <= nxt_stk1;
      stk2_ff <= nxt_stk2;
      acc_ff <= nxt_acc;
      acc_load_ff <= nxt_acc_load;
    end
  end

  // Indirect pointer; a bus write in the same cycle wins over the core
  always_comb begin
    nxt_ptr = ptr_ff;
    if (ptr_core_wr) begin
      nxt_ptr = ptr_wr_data;
    end
    if (ptr_bus_wr) begin
      nxt_ptr = pwdata[DATA_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_ff <= PTR_RESET;
    end else begin
      ptr_ff <= nxt_ptr;
    end
  end

  // Variant control register
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (ctrl_bus_wr) begin
      nxt_ctrl = pwdata[CTRL_TWO_PAGE_BIT:CTRL_BANKED_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Page clear holds through reset and one cycle after it
  always_comb begin
    nxt_page_clr = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_clr_ff <= 1'b1; // [RULE_07]
    end else begin
      page_clr_ff <= nxt_page_clr;
    end
  end

  // Reset vector is last location of the configured program space
  always_comb begin
    if (two_page) begin
      pc = pc_ff; // [RULE_06]
    end else begin
      pc = pc_ff & PC_LAST_LO; // [RULE_06] [RULE_18]
    end
  end
  assign acc = acc_ff;
  assign acc_load = acc_load_ff;
  assign status_page_clr = page_clr_ff; // [RULE_07]

  // APB read mux
  assign bus_rd_valid = psel & ~pwrite;
  always_comb begin
    prdata = APB_ZERO;
    if (bus_rd_valid) begin
      case (paddr)
        OFF_CTRL: begin
          prdata = {30'h0, ctrl_ff};
        end
        OFF_PC: begin
          prdata = {22'h0, pc};
        end
        OFF_PCL: begin
          prdata = {24'h0, pcl_val}; // [RULE_04]
        end
        OFF_PTR: begin
          prdata = {24'h0, ptr_val};
        end
        OFF_STK1: begin
          prdata = {20'h0, stk1_ff};
        end
        OFF_STK2: begin
          prdata = {20'h0, stk2_ff};
        end
        OFF_ACC: begin
          prdata = {24'h0, acc_ff};
        end
        default: begin
          prdata = APB_ZERO;
        end
      endcase
    end
  end
endmodule // pc_stack_indirect

// File: logic/pc_stack_pkg.sv
// Constants for program sequencing, stack and indirect pointer logic
package pc_stack_pkg;
  localparam int PC_W = 10;
  localparam int STK_W = 12;
  localparam int DATA_W = 8;
  localparam int INSN_W = 12;
  localparam int FADDR_W = 5;
  // Register offsets (APB byte addresses)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PC = 8'h04;
  localparam logic [7:0] OFF_PCL = 8'h08;
  localparam logic [7:0] OFF_PTR = 8'h0C;
  localparam logic [7:0] OFF_STK1 = 8'h10;
  localparam logic [7:0] OFF_STK2 = 8'h14;
  localparam logic [7:0] OFF_ACC = 8'h18;
  // Field positions
  localparam int STATUS_PAGE_BIT = 5;
  localparam int PC_PAGE_BIT = 9;
  localparam int PC_MID_BIT = 8;
  localparam int PTR_BANK_BIT = 5;
  localparam int PTR_FIXED_BIT = 6;
  localparam int PTR_SPARE_BIT = 7;
  localparam int CTRL_BANKED_BIT = 0;
  localparam int CTRL_TWO_PAGE_BIT = 1;
  // Reset and fixed values
  localparam logic [DATA_W-1:0] IND_SELF_READ = 8'h00;
  localparam logic [4:0] IND_ALIAS_ADDR = 5'h00;
  localparam logic [DATA_W-1:0] PTR_RESET = 8'hFF;
  localparam logic [PC_W-1:0] PC_ONE = 10'h001;
  localparam logic [PC_W-1:0] PC_LAST_LO = 10'h1FF;
  localparam logic [PC_W-1:0] PC_LAST_HI = 10'h3FF;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [31:0] APB_ZERO = 32'h0000_0000;
  // Instruction classes from the decoder
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_JUMP = 3'h1,
    OP_CALL = 3'h2,
    OP_RETURN_WITH_LITERAL = 3'h3,
    OP_PCL_WR = 3'h4
  } pc_op_e;
endpackage

// File: tb/pc_stack_properties.sv
// Assertion checker for the sequencing and pointer block
`timescale 1ns/1ps
module pc_stack_checker
  import pc_stack_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cycle_en,
  input wire pc_op_e pc_op,
  input wire logic [INSN_W-1:0] insn_word,
  input wire logic [DATA_W-1:0] status_reg,
  input wire logic [FADDR_W-1:0] file_addr,
  input wire logic [PC_W-1:0] pc,
  input wire logic [DATA_W-1:0] ptr_read,
  input wire logic [DATA_W-1:0] acc,
  input wire logic acc_load,
  input wire logic status_page_clr,
  input wire logic [5:0] ram_addr,
  input wire logic ram_wr,
  input wire logic [DATA_W-1:0] ind_rd_data
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_INC: assert property (cycle_en && pc_op == OP_NONE |=>
    pc[8:0] == $past(pc[8:0]) + 9'h001) else $error("pc step");
  AST_JMP: assert property (cycle_en && pc_op == OP_JUMP |=>
    pc[8:0] == $past(insn_word[8:0])) else $error("jump target");
  AST_PG: assert property (cycle_en && !status_reg[5] &&
    pc_op inside {OP_JUMP, OP_CALL, OP_PCL_WR} |=> !pc[9])
    else $error("page bit");
  AST_CALL: assert property (cycle_en && pc_op == OP_CALL |=>
    pc[8:0] == {1'b0, $past(insn_word[7:0])}) else $error("call");
  AST_ACC: assert property (cycle_en && pc_op == OP_RETURN_WITH_LITERAL |=>
    acc_load && acc == $past(insn_word[7:0])) else $error("literal");
  AST_SELF: assert property (file_addr == 5'h00 &&
    ptr_read[4:0] == 5'h00 |-> ind_rd_data == 8'h00 && !ram_wr)
    else $error("self reference");
  AST_IND: assert property (file_addr == 5'h00 |->
    ram_addr[4:0] == ptr_read[4:0]) else $error("redirect");
  AST_PTR: assert property (ptr_read[6] && !ptr_read[7])
    else $error("pointer bits");
  AST_RST: assert property ($rose(presetn) |-> status_page_clr
    ##1 !status_page_clr) else $error("page clear");
  cover property (cycle_en && pc_op == OP_RETURN_WITH_LITERAL);
  cover property (file_addr == 5'h00 && ptr_read[4:0] == 5'h00);
  cover property (cycle_en && pc_op == OP_CALL && status_reg[5]);
endmodule // pc_stack_checker
bind pc_stack_indirect pc_stack_checker pc_stack_checker_inst (
  .pclk(pclk),
  .presetn(presetn),
  .cycle_en(cycle_en),
  .pc_op(pc_op),
  .insn_word(insn_word),
  .status_reg(status_reg),
  .file_addr(file_addr),
  .pc(pc),
  .ptr_read(ptr_read),
  .acc(acc),
  .acc_load(acc_load),
  .status_page_clr(status_page_clr),
  .ram_addr(ram_addr),
  .ram_wr(ram_wr),
  .ind_rd_data(ind_rd_data)
);

// File: tb/tb.sv
// Testbench for the sequencing and pointer block
`timescale 1ns/1ps
module tb;
  import pc_stack_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic cycle_en = 0, ptr_wr = 0, file_wr = 0, pready, pslverr;
  logic acc_load, status_page_clr, ram_wr;
  logic [7:0] paddr = 0, pcl_wr_data = 0, status_reg = 0;
  logic [7:0] ptr_wr_data = 0, file_wr_data = 0, ram_rd_data = 0;
  logic [7:0] ptr_read, acc, ram_wr_data, ind_rd_data;
  logic [31:0] pwdata = 0, prdata, d;
  logic [11:0] insn_word = 0;
  logic [9:0] pc;
  logic [5:0] ram_addr;
  logic [4:0] file_addr = 0;
  pc_op_e pc_op = OP_NONE;
  int mismatches = 0, checked = 0, cyc = 0;
  pc_stack_indirect pc_stack_indirect_inst (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cycle_en(cycle_en),
    .pc_op(pc_op),
    .insn_word(insn_word),
    .pcl_wr_data(pcl_wr_data),
    .status_reg(status_reg),
    .ptr_wr(ptr_wr),
    .ptr_wr_data(ptr_wr_data),
    .file_addr(file_addr),
    .file_wr(file_wr),
    .file_wr_data(file_wr_data),
    .ram_rd_data(ram_rd_data),
    .pc(pc),
    .ptr_read(ptr_read),
    .acc(acc),
    .acc_load(acc_load),
    .status_page_clr(status_page_clr),
    .ram_addr(ram_addr),
    .ram_wr(ram_wr),
    .ram_wr_data(ram_wr_data),
    .ind_rd_data(ind_rd_data)
  );
  initial forever #20 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] wd);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    psel <= 0;
    penable <= 0;
    #1;
  endtask
  task automatic op(pc_op_e o, logic [11:0] w, logic [9:0] e);
    @(posedge pclk);
    cycle_en <= 1;
    pc_op <= o;
    insn_word <= w;
    @(posedge pclk);
    cycle_en <= 0;
    pc_op <= OP_NONE;
    #1;
    chk("pc", 32'(pc), 32'(e));
  endtask
  task automatic t_pc();
    chk("pc", 32'(pc), 32'(PC_LAST_LO));
    chk("pgclr", 32'(status_page_clr), 32'h1);
    op(OP_NONE, 12'h000, 10'h000);
    chk("pgclr", 32'(status_page_clr), 32'h0);
    op(OP_JUMP, 12'hFA5, 10'h1A5);
    op(OP_NONE, 12'h000, 10'h1A6);
    @(posedge pclk) status_reg <= 8'h20;
    op(OP_JUMP, 12'h0A5, 10'h0A5);
    apb(1, OFF_CTRL, 32'h2);
    op(OP_JUMP, 12'h0A5, 10'h2A5);
    op(OP_CALL, 12'h1FF, 10'h2FF);
    @(posedge pclk) pcl_wr_data <= 8'h33;
    op(OP_PCL_WR, 12'h000, 10'h233);
    apb(0, OFF_PCL, 0);
    chk("pcl", d, 32'h33);
    $display("t_pc done");
  endtask
  task automatic t_stk();
    op(OP_CALL, 12'h010, 10'h210);
    op(OP_CALL, 12'h020, 10'h220);
    op(OP_CALL, 12'h030, 10'h230);
    apb(0, OFF_STK2, 0);
    chk("stk2", d, 32'h211);
    op(OP_RETURN_WITH_LITERAL, 12'h055, 10'h221);
    chk("acc", 32'(acc), 32'h55);
    chk("accld", 32'(acc_load), 32'h1);
    op(OP_RETURN_WITH_LITERAL, 12'h0AA, 10'h211);
    op(OP_RETURN_WITH_LITERAL, 12'h011, 10'h211);
    apb(0, OFF_STK1, 0);
    chk("stk1", d, 32'h211);
    chk("accld", 32'(acc_load), 32'h0);
    $display("t_stk done");
  endtask
  task automatic t_ind();
    @(posedge pclk) ram_rd_data <= 8'h10;
    apb(1, OFF_PTR, 32'h1F);
    chk("ind", 32'(ind_rd_data), 32'h10);
    chk("addr", 32'(ram_addr[4:0]), 32'h1F);
    @(posedge pclk) file_wr <= 1;
    file_wr_data <= 8'h5A;
    #1;
    chk("wr", 32'(ram_wr), 32'h1);
    chk("wdata", 32'(ram_wr_data), 32'h5A);
    apb(0, OFF_PTR, 0);
    chk("ptr", d, 32'h7F);
    @(posedge pclk) ptr_wr <= 1;
    op(OP_NONE, 12'h000, 10'h212);
    @(posedge pclk) ptr_wr <= 0;
    #1;
    chk("ind", 32'(ind_rd_data), 32'h00);
    chk("wr", 32'(ram_wr), 32'h0);
    @(posedge pclk) file_wr <= 0;
    apb(1, OFF_CTRL, 32'h3);
    apb(1, OFF_PTR, 32'h25);
    chk("addr", 32'(ram_addr), 32'h25);
    apb(0, OFF_PTR, 0);
    chk("ptr", d, 32'h65);
    apb(0, 8'h40, 0);
    chk("unmapped", d, 32'h0);
    chk("slverr", 32'(pslverr), 32'h0);
    $display("t_ind done");
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    t_pc();
    t_stk();
    t_ind();
    stop_test();
  end
endmodule // tb
